// [hdl/bmca_alu.sv]
// Decimal subtract, sum-of-products loop, signed clamp and
// set-on-condition datapath behind an AXI4-Lite register slave.
// Assumes data memory answers a held request with a one-cycle ack.
//
// Behaviour
// - Decimal subtract updates sign, zero, carry
// - Plain decimal subtract ignores incoming borrow
// - Borrowing subtract uses borrow from carry
// - Byte two digits, word four, wrapping
// - Loop multiplies pointed operands, accumulates count times
// - 24-bit pointers, 16-bit count, 48-bit result
// - Accumulation overflow sets overflow flag, stops
// - Accumulation overflow requests overflow interrupt
// - Interrupt: finish step, decrement count, yield
// - Raise to floor keeps signed larger
// - Lower to ceiling keeps signed smaller
// - Range limit applies floor then ceiling
// - Clamp operations leave flags unchanged
// - Set-on-condition writes word one or zero
// - Carry conditions test borrow flag
// - Same and differ test zero flag
// - Unsigned above: carry and not zero
// - Nonnegative and negative test sign flag
// - Signed at least/below use sign xor overflow
// - Signed at most/above add zero flag
// - Overflow conditions test overflow flag
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
module bmca_alu
    import bmca_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    output logic awready,
    input wire logic [BMCA_ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [BMCA_ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output bmca_mem_req_t mem_req,
    input wire logic mem_ack,
    input wire logic [15:0] mem_rdata,
    input wire logic int_req,
    output logic int_yield,
    output logic ovf_irq
);

    // ==========================================================
    // Register bus write side
    logic aw_held, w_held, do_write, busy, wr_ok, wa_hit;
    logic [5:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;

    assign awready = !aw_held && !bvalid;
    assign wready = !w_held && !bvalid;
    assign do_write = aw_held && w_held && !bvalid;
    assign wr_ok = do_write && !busy;
    assign wa_hit = (wa & ADDR_WORD_MASK) <= OFF_RHIGH;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wa <= 6'h00;
            wd <= 32'h00000000;
            ws <= 4'h0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_held <= 1'b1;
                wa <= awaddr & ADDR_WORD_MASK;
            end
            if (wvalid && wready) begin
                w_held <= 1'b1;
                wd <= wdata;
                ws <= wstrb;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wa_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
        merge = {s[3] ? d[31:24] : old[31:24], s[2] ? d[23:16] : old[23:16],
                 s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // ==========================================================
    // Architectural state
    bmca_state_t state;
    bmca_flags_t flags;
    logic [2:0] op;
    logic word, stop_int, stop_ovf;
    logic [3:0] cond;
    logic [15:0] src1, src2, dest, count, opa, opb;
    logic [23:0] mcand_ptr, mplr_ptr;
    logic [47:0] acc;

    assign busy = state != ST_IDLE;

    wire start = wr_ok && wa == OFF_CTRL && ws[0];
    wire [2:0] next_op = wd[CTRL_OP_LSB +: 3];
    wire next_word = wd[CTRL_WORD_BIT];
    wire [3:0] next_cond = wd[CTRL_COND_LSB +: 4];
    wire sel_dest = wr_ok && wa == OFF_DEST;
    wire sel_flag = wr_ok && wa == OFF_FLAG && ws[0];

    // ==========================================================
    // Packed decimal subtract, one digit per stage
    logic [4:0] bcd_borrow;
    logic [15:0] bcd_res;
    wire is_decimal_subtract_borrow = next_op == OP_DECIMAL_SUBTRACT_BORROW;

    assign bcd_borrow[0] = is_decimal_subtract_borrow && !flags.borrow_out_bit;

    for (genvar i = 0; i < 4; i++) begin : g_digit
        wire [4:0] diff = {1'b0, dest[4*i +: 4]} - {1'b0, src1[4*i +: 4]} - {4'h0, bcd_borrow[i]};
        assign bcd_borrow[i+1] = diff[4];
        assign bcd_res[4*i +: 4] = diff[4] ? diff[3:0] + 4'hA : diff[3:0];
    end

    // Byte form stops the chain after two digits and keeps the upper byte
    wire bcd_bout = next_word ? bcd_borrow[4] : bcd_borrow[2];
    wire [15:0] bcd_dest = next_word ? bcd_res : {dest[15:8], bcd_res[7:0]};
    wire bcd_zero = next_word ? bcd_res == 16'h0000 : bcd_res[7:0] == 8'h00;
    wire bcd_neg = next_word ? bcd_res[15] : bcd_res[7];

    // ==========================================================
    // Signed clamp
    wire signed [15:0] s_src1 = next_word ? src1 : {{8{src1[7]}}, src1[7:0]};
    wire signed [15:0] s_src2 = next_word ? src2 : {{8{src2[7]}}, src2[7:0]};
    wire signed [15:0] s_dest = next_word ? dest : {{8{dest[7]}}, dest[7:0]};
    wire signed [15:0] floor_v = (s_src1 > s_dest) ? s_src1 : s_dest;
    wire signed [15:0] ceil_v = (s_src1 < s_dest) ? s_src1 : s_dest;
    wire signed [15:0] range_limit_v = (s_src2 < floor_v) ? s_src2 : floor_v;
    wire [15:0] clamp_v = next_op == OP_MAX ? floor_v : (next_op == OP_MIN ? ceil_v : range_limit_v);
    wire [15:0] clamp_dest = next_word ? clamp_v : {dest[15:8], clamp_v[7:0]};
    wire is_clamp = next_op == OP_MAX || next_op == OP_MIN || next_op == OP_RANGE_LIMIT;

    // ==========================================================
    // Condition evaluation on the flag register
    logic cond_true;
    wire sxo = flags.negative_indicator ^ flags.range_exceeded_bit;

    always_comb begin
        case (next_cond)
            CC_CARRY: cond_true = flags.borrow_out_bit;
            CC_NCARRY: cond_true = !flags.borrow_out_bit;
            CC_SAME: cond_true = flags.null_result_bit;
            CC_DIFFER: cond_true = !flags.null_result_bit;
            CC_UABOVE: cond_true = flags.borrow_out_bit && !flags.null_result_bit;
            CC_UATMOST: cond_true = !(flags.borrow_out_bit && !flags.null_result_bit);
            CC_NONNEG: cond_true = !flags.negative_indicator;
            CC_NEG: cond_true = flags.negative_indicator;
            CC_SATLEAST: cond_true = !sxo;
            CC_SBELOW: cond_true = sxo;
            CC_SATMOST: cond_true = sxo || flags.null_result_bit;
            CC_SABOVE: cond_true = !(sxo || flags.null_result_bit);
            CC_OVF: cond_true = flags.range_exceeded_bit;
            CC_NOVF: cond_true = !flags.range_exceeded_bit;
            default: cond_true = 1'b0;
        endcase
    end

    // ==========================================================
    // Sum of products
    wire signed [31:0] prod_w = $signed(opa) * $signed(opb);
    wire signed [15:0] prod_b = $signed(opa[7:0]) * $signed(opb[7:0]);
    wire [47:0] prod_ext = word ? {{16{prod_w[31]}}, prod_w} : {{32{prod_b[15]}}, prod_b};
    wire [47:0] acc_sum = acc + prod_ext;
    wire acc_ovf = acc[47] == prod_ext[47] && acc_sum[47] != acc[47];
    wire [23:0] step = word ? STEP_WORD : STEP_BYTE;
    wire [15:0] count_dec = count - 16'h0001;
    wire in_acc = state == ST_ACC;

    assign mem_req.req = state == ST_RD_A || state == ST_RD_B;
    assign mem_req.word = word;
    assign mem_req.addr = state == ST_RD_B ? mplr_ptr : mcand_ptr;

    // State machine of the accumulation loop
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_IDLE;
            opa <= RST_WORD;
            opb <= RST_WORD;
            ovf_irq <= 1'b0;
            int_yield <= 1'b0;
        end else begin
            ovf_irq <= in_acc && acc_ovf;
            int_yield <= in_acc && !acc_ovf && int_req && count_dec != 16'h0000;
            case (state)
                ST_IDLE: begin
                    if (start && next_op == OP_SOP && count != 16'h0000)
                        state <= ST_RD_A;
                end
                ST_RD_A: begin
                    if (mem_ack) begin
                        opa <= mem_rdata;
                        state <= ST_RD_B;
                    end
                end
                ST_RD_B: begin
                    if (mem_ack) begin
                        opb <= mem_rdata;
                        state <= ST_ACC;
                    end
                end
                ST_ACC: begin
                    // Interrupt is only taken here, after the step has been counted
                    if (acc_ovf || count_dec == 16'h0000 || int_req)
                        state <= ST_IDLE;
                    else
                        state <= ST_RD_A;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Register file updates
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            op <= OP_DECIMAL_SUBTRACT;
            word <= 1'b0;
            cond <= CC_CARRY;
            flags <= RST_FLAGS;
            src1 <= RST_WORD;
            src2 <= RST_WORD;
            dest <= RST_WORD;
            mcand_ptr <= 24'h000000;
            mplr_ptr <= 24'h000000;
            count <= RST_WORD;
            acc <= 48'h000000000000;
            stop_int <= 1'b0;
            stop_ovf <= 1'b0;
        end else begin
            if (start) begin
                op <= next_op;
                word <= next_word;
                cond <= next_cond;
                stop_int <= 1'b0;
                stop_ovf <= 1'b0;
                if (next_op == OP_DECIMAL_SUBTRACT || next_op == OP_DECIMAL_SUBTRACT_BORROW) begin
                    dest <= bcd_dest;
                    flags.borrow_out_bit <= !bcd_bout;
                    flags.null_result_bit <= bcd_zero;
                    flags.negative_indicator <= bcd_neg;
                end
                if (is_clamp)
                    dest <= clamp_dest;
                if (next_op == OP_SETC)
                    dest <= {15'h0000, cond_true};
            end
            if (sel_dest)
                dest <= 16'(merge({16'h0000, dest}, wd, ws));
            if (sel_flag)
                flags <= wd[3:0];
            if (wr_ok && wa == OFF_SRC1)
                src1 <= 16'(merge({16'h0000, src1}, wd, ws));
            if (wr_ok && wa == OFF_SRC2)
                src2 <= 16'(merge({16'h0000, src2}, wd, ws));
            if (wr_ok && wa == OFF_MCAND)
                mcand_ptr <= 24'(merge({8'h00, mcand_ptr}, wd, ws));
            if (wr_ok && wa == OFF_MPLR)
                mplr_ptr <= 24'(merge({8'h00, mplr_ptr}, wd, ws));
            if (wr_ok && wa == OFF_COUNT)
                count <= 16'(merge({16'h0000, count}, wd, ws));
            if (wr_ok && wa == OFF_RLOW)
                acc[15:0] <= 16'(merge({16'h0000, acc[15:0]}, wd, ws));
            if (wr_ok && wa == OFF_RMID)
                acc[31:16] <= 16'(merge({16'h0000, acc[31:16]}, wd, ws));
            if (wr_ok && wa == OFF_RHIGH)
                acc[47:32] <= 16'(merge({16'h0000, acc[47:32]}, wd, ws));
            if (in_acc && acc_ovf) begin
                flags.range_exceeded_bit <= 1'b1;
                stop_ovf <= 1'b1;
            end else if (in_acc) begin
                acc <= acc_sum;
                count <= count_dec;
                mcand_ptr <= mcand_ptr + step;
                mplr_ptr <= mplr_ptr + step;
                stop_int <= int_req && count_dec != 16'h0000;
            end
        end
    end

    // ==========================================================
    // Register bus read side
    logic [31:0] rd_val;
    logic rd_hit;
    wire [5:0] ra = araddr & ADDR_WORD_MASK;

    assign arready = !rvalid;

    always_comb begin
        rd_hit = 1'b1;
        case (ra)
            OFF_CTRL: rd_val = {24'h000000, cond, word, op};
            OFF_STAT: rd_val = {29'h00000000, stop_ovf, stop_int, busy};
            OFF_FLAG: rd_val = {28'h0000000, flags};
            OFF_SRC1: rd_val = {16'h0000, src1};
            OFF_SRC2: rd_val = {16'h0000, src2};
            OFF_DEST: rd_val = {16'h0000, dest};
            OFF_MCAND: rd_val = {8'h00, mcand_ptr};
            OFF_MPLR: rd_val = {8'h00, mplr_ptr};
            OFF_COUNT: rd_val = {16'h0000, count};
            OFF_RLOW: rd_val = {16'h0000, acc[15:0]};
            OFF_RMID: rd_val = {16'h0000, acc[31:16]};
            OFF_RHIGH: rd_val = {16'h0000, acc[47:32]};
            default: begin
                rd_val = 32'h00000000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= rd_val;
            rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    wire is_bcd = next_op == OP_DECIMAL_SUBTRACT || next_op == OP_DECIMAL_SUBTRACT_BORROW;
    bcd_flags_a: assert property (start && is_bcd |=>
        flags.borrow_out_bit == !$past(bcd_bout) && flags.null_result_bit == $past(bcd_zero))
        else $error("decimal subtract flags wrong");
    bcd_noborrow_a: assert property (start && next_op == OP_DECIMAL_SUBTRACT && dest[7:0] == src1[7:0] |=>
        dest[7:0] == 8'h00)
        else $error("plain decimal subtract used borrow");
    bcd_borrow_a: assert property (start && is_decimal_subtract_borrow && !flags.borrow_out_bit && dest == src1 |=>
        dest[7:0] == 8'h99 && !flags.borrow_out_bit)
        else $error("borrowing subtract ignored carry");

    sequence ovf_step;
        in_acc && acc_ovf;
    endsequence

    sop_stop_a: assert property (ovf_step |=> flags.range_exceeded_bit && state == ST_IDLE)
        else $error("overflow did not stop loop");

    sop_irq_a: assert property (ovf_step |=> ovf_irq ##1 !ovf_irq)
        else $error("overflow interrupt not pulsed");

    sequence int_step;
        in_acc && !acc_ovf && int_req && count_dec != 16'h0000;
    endsequence

    sop_yield_a: assert property (int_step |=>
        state == ST_IDLE && int_yield && count == $past(count) - 16'h0001)
        else $error("interrupt yield wrong");

    clamp_flags_a: assert property (start && is_clamp |=> $stable(flags))
        else $error("clamp changed flags");

    max_word_a: assert property (start && next_op == OP_MAX && next_word |=>
        dest == ($past(s_src1) > $past(s_dest) ? $past(src1) : $past(dest)))
        else $error("raise to floor wrong");

    setc_a: assert property (start && next_op == OP_SETC |=> dest == {15'h0000, $past(cond_true)})
        else $error("set on condition wrong");

endmodule // bmca_alu

// [hdl/bmca_pkg.sv]
// Constants, types and register map of the decimal, sum-of-products,
// clamp and set-on-condition datapath.
// Assumes a single 20 MHz clock domain shared with the CPU core.
package bmca_pkg;

    // ==========================================================
    // Register map (byte addresses on the AXI4-Lite slave)
    localparam int unsigned BMCA_ADDR_W = 6;
    localparam logic [5:0] OFF_CTRL = 6'h00;
    localparam logic [5:0] OFF_STAT = 6'h04;
    localparam logic [5:0] OFF_FLAG = 6'h08;
    localparam logic [5:0] OFF_SRC1 = 6'h0C;
    localparam logic [5:0] OFF_SRC2 = 6'h10;
    localparam logic [5:0] OFF_DEST = 6'h14;
    localparam logic [5:0] OFF_MCAND = 6'h18;
    localparam logic [5:0] OFF_MPLR = 6'h1C;
    localparam logic [5:0] OFF_COUNT = 6'h20;
    localparam logic [5:0] OFF_RLOW = 6'h24;
    localparam logic [5:0] OFF_RMID = 6'h28;
    localparam logic [5:0] OFF_RHIGH = 6'h2C;
    localparam logic [5:0] ADDR_WORD_MASK = 6'h3C;

    // ==========================================================
    // Control word fields
    localparam int unsigned CTRL_OP_LSB = 0;
    localparam int unsigned CTRL_WORD_BIT = 3;
    localparam int unsigned CTRL_COND_LSB = 4;

    // ==========================================================
    // Operations and conditions
    localparam logic [2:0] OP_DECIMAL_SUBTRACT = 3'h0;
    localparam logic [2:0] OP_DECIMAL_SUBTRACT_BORROW = 3'h1;
    localparam logic [2:0] OP_SOP = 3'h2;
    localparam logic [2:0] OP_MAX = 3'h3;
    localparam logic [2:0] OP_MIN = 3'h4;
    localparam logic [2:0] OP_RANGE_LIMIT = 3'h5;
    localparam logic [2:0] OP_SETC = 3'h6;

    localparam logic [3:0] CC_CARRY = 4'h0;
    localparam logic [3:0] CC_NCARRY = 4'h1;
    localparam logic [3:0] CC_SAME = 4'h2;
    localparam logic [3:0] CC_DIFFER = 4'h3;
    localparam logic [3:0] CC_UABOVE = 4'h4;
    localparam logic [3:0] CC_UATMOST = 4'h5;
    localparam logic [3:0] CC_NONNEG = 4'h6;
    localparam logic [3:0] CC_NEG = 4'h7;
    localparam logic [3:0] CC_SATLEAST = 4'h8;
    localparam logic [3:0] CC_SATMOST = 4'h9;
    localparam logic [3:0] CC_SABOVE = 4'hA;
    localparam logic [3:0] CC_SBELOW = 4'hB;
    localparam logic [3:0] CC_OVF = 4'hC;
    localparam logic [3:0] CC_NOVF = 4'hD;

    // ==========================================================
    // Reset values and step sizes
    localparam logic [3:0] RST_FLAGS = 4'h0;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [23:0] STEP_BYTE = 24'h000001;
    localparam logic [23:0] STEP_WORD = 24'h000002;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic range_exceeded_bit;
        logic borrow_out_bit;
        logic null_result_bit;
        logic negative_indicator;
    } bmca_flags_t;

    typedef struct packed {
        logic req;
        logic word;
        logic [23:0] addr;
    } bmca_mem_req_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_RD_A = 4'h2,
        ST_RD_B = 4'h4,
        ST_ACC = 4'h8
    } bmca_state_t;

endpackage

// [bench/bmca_mem_model.sv]
// Data memory partner for the sum-of-products loop.
// Assumes the datapath holds req and addr until it samples the ack.
`timescale 1ns/100ps
module bmca_mem_model
    import bmca_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire bmca_mem_req_t mem_req,
    input wire logic slow,
    output logic mem_ack,
    output logic [15:0] mem_rdata
);
    // ==========================================
    // Read port, prompt or with three wait cycles (two for the second read of a back-to-back pair)
    logic [1:0] wait_cnt;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mem_ack <= 1'b0;
            wait_cnt <= 2'h0;
            mem_rdata <= 16'h5A5A;
        end else if (mem_req.req && !mem_ack && (!slow || wait_cnt == 2'h3)) begin
            mem_ack <= 1'b1;
            wait_cnt <= 2'h0;
            mem_rdata <= mem_req.addr[15:0] + 16'h0001;
        end else begin
            // Data toggles outside an ack so a stale word never looks valid
            mem_ack <= 1'b0;
            wait_cnt <= mem_req.req ? wait_cnt + 2'h1 : 2'h0;
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule // bmca_mem_model

// [bench/test_bcd_mac_clamp_setcond_alu.sv]
// Self-checking bench: operation rows, condition sweep, loop cases.
// Assumes the data memory partner in bmca_mem_model.sv.
`timescale 1ns/100ps
module test_bcd_mac_clamp_setcond_alu
    import bmca_pkg::*;
;
    typedef struct packed {
        logic [3:0] flg;
        logic [7:0] ctrl;
        logic [15:0] s1;
        logic [15:0] s2;
        logic [15:0] d;
        logic [15:0] ed;
        logic [3:0] ef;
    } bmca_row_t;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic int_req = 0, slow = 0, awready, wready, bvalid, arready, rvalid, mem_ack, int_yield, ovf_irq;
    logic [5:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, rv;
    logic [1:0] bresp, rresp, resp;
    logic [15:0] mem_rdata;
    longint e;
    bmca_mem_req_t mem_req;
    int num_errors = 0, n_checks = 0, yields = 0, ovfs = 0;
    bmca_row_t rows [16] = '{
        '{4'h0, 8'h00, 16'h0011, 16'h0000, 16'hAB78, 16'hAB67, 4'h4},
        '{4'h8, 8'h08, 16'h1234, 16'h0000, 16'h1111, 16'h9877, 4'h9},
        '{4'h0, 8'h01, 16'h0011, 16'h0000, 16'h0078, 16'h0066, 4'h4},
        '{4'h4, 8'h01, 16'h0011, 16'h0000, 16'h0078, 16'h0067, 4'h4},
        '{4'h0, 8'h09, 16'h1111, 16'h0000, 16'h1234, 16'h0122, 4'h4},
        '{4'h1, 8'h00, 16'h0045, 16'h0000, 16'h0045, 16'h0000, 4'h6},
        '{4'h4, 8'h00, 16'h0001, 16'h0000, 16'h0000, 16'h0099, 4'h1},
        '{4'h2, 8'h09, 16'h0000, 16'h0000, 16'h0000, 16'h9999, 4'h1},
        '{4'hA, 8'h0B, 16'hFFFF, 16'h0000, 16'h0005, 16'h0005, 4'hA},
        '{4'h5, 8'h0B, 16'h0007, 16'h0000, 16'h0005, 16'h0007, 4'h5},
        '{4'hF, 8'h03, 16'h0080, 16'h0000, 16'h127F, 16'h127F, 4'hF},
        '{4'h3, 8'h0C, 16'h8000, 16'h0000, 16'h0001, 16'h8000, 4'h3},
        '{4'h0, 8'h04, 16'h00F0, 16'h0000, 16'h3405, 16'h34F0, 4'h0},
        '{4'h6, 8'h0D, 16'hFFF0, 16'h0010, 16'h0020, 16'h0010, 4'h6},
        '{4'h9, 8'h0D, 16'hFFF0, 16'h0010, 16'h8000, 16'hFFF0, 4'h9},
        '{4'hC, 8'h0D, 16'hFFF0, 16'h0010, 16'h0003, 16'h0003, 4'hC}};
    always #25 aclk = ~aclk;
    always @(posedge aclk) begin
        yields += int_yield;
        ovfs += ovf_irq;
    end
    bmca_alu bmca_alu_inst(.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready,
        .wdata, .wstrb(4'hF), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0),
        .rvalid, .rready, .rdata, .rresp, .mem_req, .mem_ack, .mem_rdata, .int_req, .int_yield, .ovf_irq);
    bmca_mem_model bmca_mem_model_inst(.aclk, .aresetn, .mem_req, .slow, .mem_ack, .mem_rdata);
    // ==========================================
    // Bus master and checking
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [5:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rv = rdata;
        resp = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic wait_idle;
        do rd(OFF_STAT); while (rv[0] !== 1'b0);
    endtask
    task automatic loop_setup(input logic [15:0] hi, input logic [15:0] lo);
        wr(OFF_FLAG, 32'h0);
        wr(OFF_RHIGH, {16'h0, hi});
        wr(OFF_RMID, {16'h0, lo});
        wr(OFF_RLOW, {16'h0, lo});
        wr(OFF_MCAND, 32'h10);
        wr(OFF_MPLR, 32'h100);
    endtask
    function automatic logic cc(input logic [3:0] c, input logic [3:0] f);
        logic s, z, cy, o;
        {o, cy, z, s} = f;
        case (c)
            4'h0: return cy;
            4'h1: return !cy;
            4'h2: return z;
            4'h3: return !z;
            4'h4: return cy & !z;
            4'h5: return !(cy & !z);
            4'h6: return !s;
            4'h7: return s;
            4'h8: return !(s ^ o);
            4'h9: return (s ^ o) | z;
            4'hA: return !((s ^ o) | z);
            4'hB: return s ^ o;
            4'hC: return o;
            default: return !o;
        endcase
    endfunction
    task automatic give_verdict;
        if (num_errors == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge aclk);
        num_errors++;
        give_verdict();
    end
    // ==========================================
    // Main sequence
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(OFF_FLAG);
        chk(rv, 32'h0, "reset flags");
        rd(6'h30);
        chk({rv[29:0], resp}, {30'h0, RESP_SLVERR}, "unmapped read");
        wr(6'h34, 32'h1);
        chk({30'h0, resp}, {30'h0, RESP_SLVERR}, "unmapped write");
        foreach (rows[i]) begin
            wr(OFF_FLAG, {28'h0, rows[i].flg});
            wr(OFF_SRC1, {16'h0, rows[i].s1});
            wr(OFF_SRC2, {16'h0, rows[i].s2});
            wr(OFF_DEST, {16'h0, rows[i].d});
            wr(OFF_CTRL, {24'h0, rows[i].ctrl});
            rd(OFF_DEST);
            chk(rv, {16'h0, rows[i].ed}, "dest");
            rd(OFF_FLAG);
            chk(rv, {28'h0, rows[i].ef}, "flags");
        end
        for (int c = 0; c < 14; c++) begin
            for (int f = 0; f < 16; f++) begin
                wr(OFF_FLAG, 32'(f));
                wr(OFF_DEST, 32'h0000FFFF);
                wr(OFF_CTRL, {24'h0, 4'(c), 4'h6});
                rd(OFF_DEST);
                chk(rv, {31'h0, cc(4'(c), 4'(f))}, "set cond");
            end
        end
        rd(OFF_CTRL);
        chk(rv, 32'hD6, "ctrl readback");
        // Interrupt held high: one step completes, then the loop yields
        loop_setup(16'h0, 16'h0);
        wr(OFF_COUNT, 32'h3);
        slow <= 1'b1;
        int_req <= 1'b1;
        wr(OFF_CTRL, 32'h0A);
        wait_idle();
        chk(rv, 32'h2, "stat yield");
        int_req <= 1'b0;
        rd(OFF_COUNT);
        chk(rv, 32'h2, "count after yield");
        chk(yields, 1, "yield pulses");
        wr(OFF_CTRL, 32'h0A);
        wait_idle();
        chk(rv, 32'h0, "stat done");
        e = 0;
        for (int i = 0; i < 3; i++) e += (17 + 2 * i) * (257 + 2 * i);
        rd(OFF_RLOW);
        chk(rv, {16'h0, e[15:0]}, "sum low");
        rd(OFF_RMID);
        chk(rv, {16'h0, e[31:16]}, "sum mid");
        rd(OFF_RHIGH);
        chk(rv, 32'h0, "sum high");
        rd(OFF_MCAND);
        chk(rv, 32'h16, "pointer step");
        rd(OFF_MPLR);
        chk(rv, 32'h106, "multiplier step");
        rd(OFF_COUNT);
        chk(rv, 32'h0, "count done");
        // Accumulator at its positive limit overflows on the first product
        slow <= 1'b0;
        loop_setup(16'h7FFF, 16'hFFFF);
        wr(OFF_COUNT, 32'h2);
        wr(OFF_CTRL, 32'h0A);
        wait_idle();
        chk(rv, 32'h4, "stat overflow");
        rd(OFF_FLAG);
        chk(rv, 32'h8, "overflow flag");
        rd(OFF_COUNT);
        chk(rv, 32'h2, "stopped count");
        chk(ovfs, 1, "overflow irq");
        // Byte loop: multiplier low bytes 1 and 2, pointers step by one
        loop_setup(16'h0, 16'h0);
        wr(OFF_COUNT, 32'h2);
        wr(OFF_CTRL, 32'h02);
        wait_idle();
        rd(OFF_RLOW);
        chk(rv, 32'h35, "byte sum");
        rd(OFF_MCAND);
        chk(rv, 32'h12, "byte step");
        // Reset in mid-loop abandons the run and clears the registers
        slow <= 1'b1;
        wr(OFF_COUNT, 32'h9);
        wr(OFF_CTRL, 32'h0A);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(OFF_STAT);
        chk(rv, 32'h0, "stat after reset");
        rd(OFF_COUNT);
        chk(rv, 32'h0, "count after reset");
        give_verdict();
    end
endmodule // test_bcd_mac_clamp_setcond_alu
